// ---- hw/fp_register_move.sv ----
// Decoder and executor of floating-point register copies, with its register file
module fp_register_move #(
   parameter bit QUAD_AS_ILLEGAL = 1'b1
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        instr_valid,
   input  wire logic        instr_cond_form,
   input  wire logic [31:0] instr,
   input  wire logic [3:0]  icc,
   input  wire logic [3:0]  xcc,
   input  wire logic [7:0]  fcc,
   input  wire logic        fp_status_enable_bit,
   input  wire logic        processor_fp_enable,
   output logic             instr_ready,
   output logic             copy_done,
   output logic             copy_written,
   output logic             trap_illegal,
   output logic             fpu_off_trap,
   output logic             other_float_trap,
   output logic             irq,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata
);

   // Integer condition test; upper cond bit negates the lower eight tests
   function automatic logic int_test(input logic [3:0] c, input logic [3:0] cc);
      logic t;
      t = 1'b0;
      unique case (c[2:0])
         3'h0: t = 1'b0;
         3'h1: t = cc[fp_copy_pkg::CC_Z];
         3'h2: t = cc[fp_copy_pkg::CC_Z] | (cc[fp_copy_pkg::CC_N] ^ cc[fp_copy_pkg::CC_V]);
         3'h3: t = cc[fp_copy_pkg::CC_N] ^ cc[fp_copy_pkg::CC_V];
         3'h4: t = cc[fp_copy_pkg::CC_C] | cc[fp_copy_pkg::CC_Z];
         3'h5: t = cc[fp_copy_pkg::CC_C];
         3'h6: t = cc[fp_copy_pkg::CC_N];
         3'h7: t = cc[fp_copy_pkg::CC_V];
      endcase
      return t ^ c[3];
   endfunction

   // Floating-point condition test on one two-bit field
   function automatic logic fp_test(input logic [3:0] c, input logic [1:0] f);
      logic e, l, g, u, t;
      e = (f == fp_copy_pkg::FCC_E);
      l = (f == fp_copy_pkg::FCC_L);
      g = (f == fp_copy_pkg::FCC_G);
      u = (f == fp_copy_pkg::FCC_U);
      t = 1'b0;
      unique case (c[2:0])
         3'h0: t = 1'b0;
         3'h1: t = l | g | u;
         3'h2: t = l | g;
         3'h3: t = l | u;
         3'h4: t = l;
         3'h5: t = g | u;
         3'h6: t = g;
         3'h7: t = u;
      endcase
      return t ^ c[3];
   endfunction

   // Condition-source selects that name no condition code
   function automatic logic sel_reserved(input logic [2:0] s);
      return (s == fp_copy_pkg::CC_RSV_A) || (s == fp_copy_pkg::CC_RSV_B);
   endfunction

   // Word index of a register-file access, shared by bus writes and reads
   function automatic logic [fp_copy_pkg::FPR_IW-1:0] fpr_index(input logic [7:0] a);
      return a[fp_copy_pkg::WORD_LSB +: fp_copy_pkg::FPR_IW];
   endfunction

   // Bus write aimed at one control-space offset
   function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] o);
      return w && (a == o);
   endfunction

   // Register file and software-visible state
   logic [31:0]                 fpr_q [fp_copy_pkg::FPR_N];
   logic [31:0]                 fsr_q;
   logic [fp_copy_pkg::EV_W-1:0] status_q;
   logic [fp_copy_pkg::EV_W-1:0] mask_q;
   logic [fp_copy_pkg::CTRL_W-1:0] ctrl_q;

   // Decode and execute results
   logic [fp_copy_pkg::EV_W-1:0] ev;
   fp_copy_pkg::width_t         wid;
   logic [5:0]                  opf;
   logic [2:0]                  ccsel;
   logic [3:0]                  cond;
   logic [4:0]                  rs2_f;
   logic [4:0]                  rd_f;
   logic                        take;
   logic                        illegal;
   logic                        fpu_on;
   logic                        is_quad;
   logic                        cond_true;
   logic                        execute;
   logic                        do_write;
   logic [fp_copy_pkg::FPR_IW-1:0] dst_lo;
   logic [fp_copy_pkg::FPR_IW-1:0] src_lo;

   // Field extraction
   assign opf    = instr[fp_copy_pkg::OPF_LSB +: fp_copy_pkg::OPF_W];
   assign ccsel  = instr[fp_copy_pkg::CCSEL_LSB +: fp_copy_pkg::CCSEL_W];
   assign cond   = instr[fp_copy_pkg::COND_LSB +: fp_copy_pkg::COND_W];
   assign rs2_f  = instr[fp_copy_pkg::RS2_LSB +: fp_copy_pkg::FPR_IW];
   assign rd_f   = instr[fp_copy_pkg::RD_LSB +: fp_copy_pkg::FPR_IW];
   assign take   = instr_valid & instr_ready;
   // The FPU counts as on only with presence and both enables high
   assign fpu_on = ctrl_q[fp_copy_pkg::CTRL_FPU] & fp_status_enable_bit
                   & processor_fp_enable;

   // Width from the low opcode field
   always_comb begin
      unique case (opf)
         fp_copy_pkg::OPF_S: wid = fp_copy_pkg::W_SINGLE;
         fp_copy_pkg::OPF_D: wid = fp_copy_pkg::W_DOUBLE;
         fp_copy_pkg::OPF_Q: wid = fp_copy_pkg::W_QUAD;
         default:            wid = fp_copy_pkg::W_BAD;
      endcase
   end
   assign is_quad = (wid == fp_copy_pkg::W_QUAD);

   // Illegal encodings; quad counts here when QUAD_AS_ILLEGAL is set
   always_comb begin
      illegal = (wid == fp_copy_pkg::W_BAD) | (is_quad & QUAD_AS_ILLEGAL);
      if (instr_cond_form) begin
         illegal = illegal | instr[fp_copy_pkg::RSV_HI]
                   | sel_reserved(ccsel);
      end else begin
         illegal = illegal
                   | (|instr[fp_copy_pkg::RSV_HI:fp_copy_pkg::RSV_LO]);
      end
   end

   // Condition source select
   always_comb begin
      if (!instr_cond_form) begin
         cond_true = 1'b1;
      end else if (ccsel == fp_copy_pkg::CC_ICC) begin
         cond_true = int_test(cond, icc);
      end else if (ccsel == fp_copy_pkg::CC_XCC) begin
         cond_true = int_test(cond, xcc);
      end else begin
         cond_true = fp_test(cond, fcc[{ccsel[1:0], 1'b0} +: 2]);
      end
   end

   // Trap priority: illegal, then disabled, then unimplemented
   always_comb begin
      ev = '0;
      execute = 1'b0;
      if (take) begin
         if (illegal) begin
            ev[fp_copy_pkg::EV_ILL] = 1'b1;
         end else if (!fpu_on) begin
            ev[fp_copy_pkg::EV_OFF] = 1'b1;
         end else if (is_quad) begin
            ev[fp_copy_pkg::EV_OTHER] = 1'b1;
         end else begin
            ev[fp_copy_pkg::EV_DONE] = 1'b1;
            execute = 1'b1;
         end
      end
   end
   assign do_write = execute & cond_true;

   // Doubles use an even-aligned register pair
   always_comb begin
      if (wid == fp_copy_pkg::W_DOUBLE) begin
         dst_lo = {rd_f[4:1], 1'b0};
         src_lo = {rs2_f[4:1], 1'b0};
      end else begin
         dst_lo = rd_f;
         src_lo = rs2_f;
      end
   end

   // Register array; a copy beats a bus write to the same word
   always_ff @(posedge clock) begin
      if (wr && addr[fp_copy_pkg::FPR_SEL]) begin
         fpr_q[fpr_index(addr)] <= wdata;
      end
      if (do_write) begin
         fpr_q[dst_lo] <= fpr_q[src_lo];
         if (wid == fp_copy_pkg::W_DOUBLE) begin
            fpr_q[dst_lo | 5'h01] <= fpr_q[src_lo | 5'h01];
         end
      end
   end

   // State register: copy clears cexc and ftt, aexc changes only by a bus write
   always_ff @(posedge clock) begin
      if (rst) begin
         fsr_q <= fp_copy_pkg::FSR_RST;
      end else begin
         if (wr_hit(wr, addr, fp_copy_pkg::OFS_FSR)) begin
            fsr_q <= wdata;
         end
         if (execute) begin
            fsr_q[fp_copy_pkg::CEXC_LSB +: fp_copy_pkg::CEXC_W] <= '0;
            fsr_q[fp_copy_pkg::FTT_LSB +: fp_copy_pkg::FTT_W] <= '0;
         end else if (ev[fp_copy_pkg::EV_OTHER]) begin
            fsr_q[fp_copy_pkg::FTT_LSB +: fp_copy_pkg::FTT_W] <= fp_copy_pkg::FTT_UNIMP;
         end
      end
   end

   // Result pulses toward the pipeline
   // Exactly one of the four answers follows each taken word
   always_ff @(posedge clock) begin
      if (rst) begin
         copy_done        <= 1'b0;
         copy_written     <= 1'b0;
         trap_illegal     <= 1'b0;
         fpu_off_trap     <= 1'b0;
         other_float_trap <= 1'b0;
      end else begin
         copy_done        <= ev[fp_copy_pkg::EV_DONE];
         copy_written     <= do_write;
         trap_illegal     <= ev[fp_copy_pkg::EV_ILL];
         fpu_off_trap     <= ev[fp_copy_pkg::EV_OFF];
         other_float_trap <= ev[fp_copy_pkg::EV_OTHER];
      end
   end

   // Control and mask; clearing the enable stalls the pipeline
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_q <= fp_copy_pkg::CTRL_RST;
         mask_q <= '0;
      end else if (wr) begin
         if (addr == fp_copy_pkg::OFS_CTRL) begin
            ctrl_q <= wdata[fp_copy_pkg::CTRL_W-1:0];
         end
         if (addr == fp_copy_pkg::OFS_MASK) begin
            mask_q <= wdata[fp_copy_pkg::EV_W-1:0];
         end
      end
   end

   // Sticky status; a new event wins over a write-one-to-clear
   always_ff @(posedge clock) begin
      if (rst) begin
         status_q <= '0;
      end else if (wr_hit(wr, addr, fp_copy_pkg::OFS_STATUS)) begin
         status_q <= (status_q & ~wdata[fp_copy_pkg::EV_W-1:0]) | ev;
      end else begin
         status_q <= status_q | ev;
      end
   end

   // Interrupt level and ready, both registered
   // Ready lags the enable by a cycle, so one more word may be taken
   always_ff @(posedge clock) begin
      if (rst) begin
         irq         <= 1'b0;
         instr_ready <= 1'b0;
      end else begin
         irq         <= |(status_q & mask_q);
         instr_ready <= ctrl_q[fp_copy_pkg::CTRL_EN];
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   // Reads have no side effect; status clears only by a write
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata <= '0;
      end else if (!rd) begin
         rdata <= '0;
      end else if (addr[fp_copy_pkg::FPR_SEL]) begin
         rdata <= fpr_q[fpr_index(addr)];
      end else begin
         unique case (addr)
            fp_copy_pkg::OFS_STATUS: rdata <= 32'(status_q);
            fp_copy_pkg::OFS_MASK:   rdata <= 32'(mask_q);
            fp_copy_pkg::OFS_CTRL:   rdata <= 32'(ctrl_q);
            fp_copy_pkg::OFS_FSR:    rdata <= fsr_q;
            default:                 rdata <= '0;
         endcase
      end
   end

endmodule

// ---- hw/fp_copy_pkg.sv ----
// Constants shared by the floating-point register copy decoder
package fp_copy_pkg;
   // Register bus geometry
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned FPR_N    = 32;
   localparam int unsigned FPR_IW   = 5;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_FSR    = 8'h0C;
   localparam logic [7:0] OFS_FPR    = 8'h80;
   localparam int unsigned FPR_SEL   = 7;
   localparam int unsigned WORD_LSB  = 2;
   // Event bits of status and mask
   localparam int unsigned EV_W      = 4;
   localparam int unsigned EV_DONE   = 0;
   localparam int unsigned EV_ILL    = 1;
   localparam int unsigned EV_OFF    = 2;
   localparam int unsigned EV_OTHER  = 3;
   // Control register
   localparam int unsigned CTRL_W    = 2;
   localparam int unsigned CTRL_EN   = 0;
   localparam int unsigned CTRL_FPU  = 1;
   localparam logic [1:0]  CTRL_RST  = 2'h3;
   // State register fields
   localparam int unsigned CEXC_LSB  = 0;
   localparam int unsigned CEXC_W    = 5;
   localparam int unsigned FTT_LSB   = 14;
   localparam int unsigned FTT_W     = 3;
   localparam logic [2:0]  FTT_UNIMP = 3'h3;
   localparam logic [31:0] FSR_RST   = 32'h0000_0000;
   // Instruction fields
   localparam int unsigned RD_LSB    = 25;
   localparam int unsigned RS2_LSB   = 0;
   localparam int unsigned OPF_LSB   = 5;
   localparam int unsigned OPF_W     = 6;
   localparam int unsigned CCSEL_LSB = 11;
   localparam int unsigned COND_LSB  = 14;
   localparam int unsigned RSV_HI    = 18;
   localparam int unsigned RSV_LO    = 14;
   localparam logic [5:0]  OPF_S     = 6'h01;
   localparam logic [5:0]  OPF_D     = 6'h02;
   localparam logic [5:0]  OPF_Q     = 6'h03;
   localparam logic [2:0]  CC_ICC    = 3'h4;
   localparam logic [2:0]  CC_XCC    = 3'h6;
   localparam logic [2:0]  CC_RSV_A  = 3'h5;
   localparam logic [2:0]  CC_RSV_B  = 3'h7;
   localparam int unsigned CCSEL_W   = 3;
   localparam int unsigned COND_W    = 4;
   // Integer code bit positions {n,z,v,c}
   localparam int unsigned CC_N = 3;
   localparam int unsigned CC_Z = 2;
   localparam int unsigned CC_V = 1;
   localparam int unsigned CC_C = 0;
   // Floating-point condition values
   localparam logic [1:0]  FCC_E = 2'h0;
   localparam logic [1:0]  FCC_L = 2'h1;
   localparam logic [1:0]  FCC_G = 2'h2;
   localparam logic [1:0]  FCC_U = 2'h3;
   typedef enum logic [1:0] {W_SINGLE, W_DOUBLE, W_QUAD, W_BAD} width_t;
endpackage

// ---- verification/fp_register_move_monitor.sv ----
// Checker of the copy decoder's port behaviour
module fp_register_move_monitor (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        instr_valid,
   input wire logic        instr_cond_form,
   input wire logic [31:0] instr,
   input wire logic        fp_status_enable_bit,
   input wire logic        processor_fp_enable,
   input wire logic        instr_ready,
   input wire logic        copy_done,
   input wire logic        copy_written,
   input wire logic        trap_illegal,
   input wire logic        fpu_off_trap,
   input wire logic        other_float_trap
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Decode of the taken word; quad is refused as illegal in this build
   wire       tk = instr_valid & instr_ready;
   wire [5:0] op = instr[10:5];
   wire [2:0] sl = instr[13:11];
   wire       ccr = instr[18] | sl == 3'h5 | sl == 3'h7;
   wire       rsv = instr_cond_form ? ccr : |instr[18:14];
   wire       bad = rsv | !(op == 6'h01 | op == 6'h02);
   wire       en = fp_status_enable_bit & processor_fp_enable;
   wire [3:0] ev = {copy_done, trap_illegal, fpu_off_trap, other_float_trap};
   property p_one; tk |=> $onehot(ev); endproperty
   a_one: assert property (p_one) else $error("not one answer");
   property p_rsv; tk && !instr_cond_form && |instr[18:14] |=> trap_illegal; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits taken");
   property p_ccrsv; tk && instr_cond_form && ccr |=> trap_illegal; endproperty
   a_ccrsv: assert property (p_ccrsv) else $error("bad cond form taken");
   property p_quad; tk && op == 6'h03 |=> trap_illegal && !copy_written; endproperty
   a_quad: assert property (p_quad) else $error("quad executed");
   property p_off; tk && !bad && !en |=> fpu_off_trap; endproperty
   a_off: assert property (p_off) else $error("disabled not trapped");
   property p_prio; tk && bad && !en |=> trap_illegal && !fpu_off_trap; endproperty
   a_prio: assert property (p_prio) else $error("trap order wrong");
   property p_never; tk && instr_cond_form && !bad && instr[17:14] == 4'h0 |=> !copy_written;
   endproperty
   a_never: assert property (p_never) else $error("never cond wrote");
   property p_wr; copy_written |-> copy_done && $past(tk); endproperty
   a_wr: assert property (p_wr) else $error("write without copy");
endmodule

bind fp_register_move fp_register_move_monitor i_mon (.clock(clock), .rst(rst),
   .instr_valid(instr_valid), .instr_cond_form(instr_cond_form), .instr(instr),
   .fp_status_enable_bit(fp_status_enable_bit), .processor_fp_enable(processor_fp_enable),
   .instr_ready(instr_ready), .copy_done(copy_done), .copy_written(copy_written),
   .trap_illegal(trap_illegal), .fpu_off_trap(fpu_off_trap),
   .other_float_trap(other_float_trap));

// ---- verification/tb_fp_register_move.sv ----
// Self-checking bench for the floating-point register copy decoder
module tb_fp_register_move;
   timeunit 1ns;
   timeprecision 1ns;
   // Fp cond masks, one nibble per cond value, bit index is the fcc value
   localparam logic [63:0] FTBL = 64'h7B3D_591F_84C2_A6E0;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        instr_valid = 1'b0;
   logic        instr_cond_form = 1'b0;
   logic [31:0] instr = 32'h0;
   logic [3:0]  icc = 4'h0;
   logic [3:0]  xcc = 4'h0;
   logic [7:0]  fcc = 8'h0;
   logic        fp_status_enable_bit = 1'b1;
   logic        processor_fp_enable = 1'b1;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        instr_ready, copy_done, copy_written, trap_illegal;
   logic        fpu_off_trap, other_float_trap, irq;
   logic [31:0] rdata;
   logic [31:0] seed = 32'h5DAA;
   logic [31:0] fm [32];
   int          fails = 0;
   int          n_tests = 0;

   fp_register_move i_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
      .instr_cond_form(instr_cond_form), .instr(instr), .icc(icc), .xcc(xcc), .fcc(fcc),
      .fp_status_enable_bit(fp_status_enable_bit), .processor_fp_enable(processor_fp_enable),
      .instr_ready(instr_ready), .copy_done(copy_done), .copy_written(copy_written),
      .trap_illegal(trap_illegal), .fpu_off_trap(fpu_off_trap),
      .other_float_trap(other_float_trap), .irq(irq), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));

   // 100 ns clock
   initial forever #50 clock = ~clock;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] fa(logic [4:0] x);
      return fp_copy_pkg::OFS_FPR | {1'b0, x, 2'b00};
   endfunction

   // Condition outcome; integer tests come in true/false pairs split by cond[3]
   function automatic logic cond_ok(logic [2:0] s, logic [3:0] c, logic [3:0] ic,
                                    logic [3:0] xc, logic [7:0] fc);
      logic [3:0] f;
      logic       b;
      f = (s == 3'h6) ? xc : ic;
      case (c[2:0])
         3'h0: b = 1'b0;
         3'h1: b = f[2];
         3'h2: b = f[2] | (f[3] ^ f[1]);
         3'h3: b = f[3] ^ f[1];
         3'h4: b = f[0] | f[2];
         3'h5: b = f[0];
         3'h6: b = f[3];
         default: b = f[1];
      endcase
      if (!s[2]) return FTBL[{c, fc[2 * s[1:0] +: 2]}];
      return b ^ c[3];
   endfunction

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic bw(logic [7:0] a, logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rc(logic [7:0] a, logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   task automatic iss(logic cf, logic [31:0] w, logic [4:0] e);
      instr_cond_form <= cf;
      instr <= w;
      instr_valid <= 1'b1;
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      chk({27'h0, copy_done, copy_written, trap_illegal, fpu_off_trap, other_float_trap},
          {27'h0, e});
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence: registers, random copies, interrupts, decode enable
   initial begin
      int          n;
      logic [31:0] r, ins;
      logic        cf, ill, off, wt;
      logic [5:0]  op;
      logic [4:0]  d, s;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      n = 0;
      while (n < 20 && instr_ready !== 1'b1) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (instr_ready !== 1'b1) begin
         fails++;
         end_of_test();
      end
      rc(fp_copy_pkg::OFS_CTRL, 32'h3);
      rc(fp_copy_pkg::OFS_FSR, fp_copy_pkg::FSR_RST);
      rc(8'h40, 32'h0);
      bw(fp_copy_pkg::OFS_MASK, 32'h0);
      bw(fp_copy_pkg::OFS_STATUS, 32'hF);
      for (n = 0; n < 32; n++) begin
         fm[n] = (n == 3) ? 32'h7FC0_0001 : rnd();
         bw(fa(5'(n)), fm[n]);
      end
      $display("end of register setup");
      // Random words, under half of them legal; the FPU is reported absent from step 100
      for (n = 0; n < 150; n++) begin
         r = rnd();
         ins = rnd();
         cf = r[0];
         if (r[2:1] != 2'h0) ins[18:14] = {1'b0, ins[17:14] & {4{cf}}};
         if (r[4:3] != 2'h0) ins[10:5] = (r[6:5] == 2'h0) ? 6'h01 : {4'h0, r[6:5]};
         if (n == 100) bw(fp_copy_pkg::OFS_CTRL, 32'h1);
         icc <= r[11:8];
         xcc <= r[15:12];
         fcc <= r[23:16];
         fp_status_enable_bit <= r[26:24] != 3'h0;
         processor_fp_enable <= r[29:27] != 3'h0;
         op = ins[10:5];
         ill = cf ? ins[18] | ins[13:11] == 3'h5 | ins[13:11] == 3'h7 : |ins[18:14];
         ill = ill | !(op == 6'h01 || op == 6'h02);
         off = !(r[26:24] != 3'h0 && r[29:27] != 3'h0 && n < 100);
         wt = !ill && !off && (!cf || cond_ok(ins[13:11], ins[17:14], r[11:8], r[15:12],
                                               r[23:16]));
         d = ins[29:25] & {4'hF, op != 6'h02};
         s = ins[4:0] & {4'hF, op != 6'h02};
         iss(cf, ins, {!ill && !off, wt, ill, !ill && off, 1'b0});
         if (wt) fm[d] = fm[s];
         if (wt && op == 6'h02) fm[d + 5'h1] = fm[s + 5'h1];
         rc(fa(d), fm[d]);
         if (op == 6'h02) rc(fa(d + 5'h1), fm[d + 5'h1]);
      end
      $display("end of random copies");
      bw(fp_copy_pkg::OFS_CTRL, 32'h3);
      fp_status_enable_bit <= 1'b1;
      processor_fp_enable <= 1'b1;
      bw(fp_copy_pkg::OFS_FSR, 32'hFFFF_FFFF);
      iss(1'b0, 32'h0A00_0022, 5'h18);
      rc(fp_copy_pkg::OFS_FSR, 32'hFFFE_3FE0);
      rc(fa(5'h5), fm[2]);
      // Back-to-back words: the second reads what the first just wrote
      iss(1'b0, 32'h0C00_0022, 5'h18);
      iss(1'b1, 32'h0E02_2026, 5'h18);
      rc(fa(5'h6), fm[2]);
      rc(fa(5'h7), fm[2]);
      rc(fp_copy_pkg::OFS_STATUS, 32'h7);
      chk({31'h0, irq}, 32'h0);
      bw(fp_copy_pkg::OFS_MASK, 32'h2);
      @(posedge clock);
      #1;
      chk({31'h0, irq}, 32'h1);
      bw(fp_copy_pkg::OFS_STATUS, 32'h2);
      @(posedge clock);
      #1;
      chk({31'h0, irq}, 32'h0);
      rc(fp_copy_pkg::OFS_STATUS, 32'h5);
      $display("end of interrupt test");
      // Decode disabled: a presented word must draw no answer
      bw(fp_copy_pkg::OFS_CTRL, 32'h2);
      @(posedge clock);
      #1;
      chk({31'h0, instr_ready}, 32'h0);
      iss(1'b0, 32'h0A00_0022, 5'h00);
      $display("end of decode enable test");
      end_of_test();
   end
endmodule
